// ===== shared/tlec_pkg.sv
// ==========================================================================
// Shared constants of the two-level event controller.
// ==========================================================================
package tlec_pkg;

  // ========================================================================
  // Sizes.
  // ========================================================================
  localparam int NUM_EVT = 16;
  localparam int NUM_SRC = 64;
  localparam int NUM_GP  = 9;
  localparam int GP_BASE = 7;
  localparam int ASG_W   = 4;

  // ========================================================================
  // Register byte offsets.
  // ========================================================================
  localparam logic [7:0] OFF_LATCH   = 8'h00;
  localparam logic [7:0] OFF_MASK    = 8'h04;
  localparam logic [7:0] OFF_PEND    = 8'h08;
  localparam logic [7:0] OFF_GIE     = 8'h0C;
  localparam logic [7:0] OFF_SMASK   = 8'h10;
  localparam logic [7:0] OFF_SSTAT   = 8'h18;
  localparam logic [7:0] OFF_WAKE    = 8'h20;
  localparam logic [7:0] OFF_EVSTAT  = 8'h30;
  localparam logic [7:0] OFF_EVCLR   = 8'h34;
  localparam logic [7:0] OFF_EVEN    = 8'h38;
  localparam logic [7:0] OFF_ASG     = 8'h40;

  // ========================================================================
  // Reset values.
  // ========================================================================
  localparam logic [15:0]  RST_CORE_MASK = 16'h0000;
  localparam logic         RST_GIE       = 1'b0;
  localparam logic [63:0]  RST_SYS_MASK  = 64'h0000_0000_0000_0000;
  localparam logic [63:0]  RST_WAKE      = 64'h0000_0000_0000_0000;
  localparam logic [2:0]   RST_EVEN      = 3'h0;
  // Default routing, one nibble per source, source 0 in the low nibble.
  localparam logic [255:0] RST_ASG_ALL   = {32'h0000_0000, 32'h3333_3003, 32'h0666_6655, 32'h5555_5555,
                                            32'h0444_4433, 32'h3333_2222, 32'h2211_0000, 32'h0000_0000};

  // ========================================================================
  // Block event bits (sticky status, clear and enable registers).
  // ========================================================================
  localparam int EVB_WAKE = 0;
  localparam int EVB_DENY = 1;
  localparam int EVB_OVR  = 2;
  localparam int EV_W     = 3;

endpackage

// ===== verilog/tlec_top.sv
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module tlec_top
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [2:0]  pprot,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral sources and fixed core events.
  input  wire logic [63:0] periph_irq,
  input  wire logic [6:0]  core_fixed_evt,
  // Pipeline side.
  input  wire logic        global_irq_enable_instr,
  input  wire logic        global_irq_disable_instr,
  input  wire logic        core_idle,
  input  wire logic        pipe_accept,
  input  wire logic [3:0]  pipe_accept_id,
  input  wire logic        pipe_return,
  input  wire logic [3:0]  pipe_return_id,
  output var  logic        evt_req,
  output var  logic [3:0]  evt_req_id,
  output var  logic        core_wakeup,
  // Block interrupt.
  output logic             irq
);

  // ========================================================================
  // Helpers.
  // ========================================================================
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
        r = 5'(i);
    end
    return r;
  endfunction

  // ========================================================================
  // State.
  // ========================================================================
  logic [15:0]             latch_reg;
  logic [15:0]             mask_reg;
  logic [15:0]             pending_reg;
  logic                    gie_reg;
  logic [63:0]             smask_reg;
  logic [63:0]             wake_reg;
  logic [tlec_pkg::ASG_W-1:0] asg_reg [tlec_pkg::NUM_SRC];
  logic [15:0]             edge_prev_reg;
  logic [15:0]             rise_reg;
  logic [tlec_pkg::EV_W-1:0] evstat_reg;
  logic [tlec_pkg::EV_W-1:0] even_reg;

  // ========================================================================
  // APB decode.
  // ========================================================================
  wire logic acc_w     = psel & penable;
  wire logic setup_w   = psel & ~penable;
  wire logic sel_latch = (paddr == tlec_pkg::OFF_LATCH);
  wire logic sel_mask  = (paddr == tlec_pkg::OFF_MASK);
  wire logic sel_pend  = (paddr == tlec_pkg::OFF_PEND);
  wire logic sel_gie   = (paddr == tlec_pkg::OFF_GIE);
  wire logic sel_smask = (paddr[7:3] == tlec_pkg::OFF_SMASK[7:3]);
  wire logic sel_sstat = (paddr[7:3] == tlec_pkg::OFF_SSTAT[7:3]);
  wire logic sel_wake  = (paddr[7:3] == tlec_pkg::OFF_WAKE[7:3]);
  wire logic sel_evst  = (paddr == tlec_pkg::OFF_EVSTAT);
  wire logic sel_evclr = (paddr == tlec_pkg::OFF_EVCLR);
  wire logic sel_even  = (paddr == tlec_pkg::OFF_EVEN);
  wire logic sel_asg   = (paddr[7:5] == tlec_pkg::OFF_ASG[7:5]);
  wire logic mapped_w  = sel_latch | sel_mask | sel_pend | sel_gie | sel_smask | sel_sstat | sel_wake |
                         sel_evst | sel_evclr | sel_even | sel_asg;
  // Mask and pending belong to the supervisor; an unprivileged access is refused.
  wire logic priv_bad_w = (sel_mask | sel_pend) & ~pprot[0];
  wire logic ro_bad_w   = pwrite & (sel_pend | sel_gie | sel_sstat | sel_evst);
  wire logic err_w      = ~mapped_w | priv_bad_w | ro_bad_w;
  // A refused access changes no register but sets the deny event bit, and reads back as zero.
  wire logic wr_w       = acc_w & pwrite & ~err_w;
  wire logic hi_w       = paddr[2];

  // Every register answers in its first access cycle, so no wait state is ever inserted.
  assign pready  = 1'b1;
  assign pslverr = acc_w & err_w;

  // ========================================================================
  // System stage: masking, routing and merging onto the inputs.
  // ========================================================================
  logic [tlec_pkg::NUM_GP-1:0] route_w [tlec_pkg::NUM_SRC];
  logic [tlec_pkg::NUM_GP-1:0] gp_vec;

  genvar gs;
  generate
    for (gs = 0; gs < tlec_pkg::NUM_SRC; gs++)
    begin : g_route
      // Fields above the last input route a source nowhere.
      assign route_w[gs] = (periph_irq[gs] & smask_reg[gs] & (asg_reg[gs] < 4'(tlec_pkg::NUM_GP))) ?
                           (9'h001 << asg_reg[gs]) : 9'h000;
    end
  endgenerate

  always_comb
  begin
    gp_vec = '0;
    for (int s = 0; s < tlec_pkg::NUM_SRC; s++)
      gp_vec = gp_vec | route_w[s];
  end

  wire logic [15:0] evt_in_w = {gp_vec, core_fixed_evt};
  wire logic        wake_src_w = |(periph_irq & wake_reg);

  // ========================================================================
  // Core stage: latch, service selection and pending.
  // ========================================================================
  wire logic [15:0] acc_hot_w = 16'h0001 << pipe_accept_id;
  wire logic [15:0] ret_hot_w = 16'h0001 << pipe_return_id;
  // The pipeline may only take the event currently offered.
  wire logic        take_w    = pipe_accept & evt_req & (pipe_accept_id == evt_req_id);
  wire logic [15:0] pend_set_w = take_w ? acc_hot_w : 16'h0000;
  wire logic [15:0] pend_clr_w = pipe_return ? ret_hot_w : 16'h0000;
  wire logic [15:0] lat_wm_w  = (wr_w & sel_latch) ? ~mask_reg : 16'h0000;
  wire logic [15:0] lat_sw_w  = (latch_reg & ~lat_wm_w) | (pwdata[15:0] & lat_wm_w);
  // A fresh edge wins over the clear caused by acceptance, so it stays queued.
  wire logic [15:0] latch_next   = (lat_sw_w & ~pend_set_w) | rise_reg;
  wire logic [15:0] pending_next = (pending_reg & ~pend_clr_w) | pend_set_w;
  wire logic [15:0] mask_next    = (wr_w & sel_mask) ? pwdata[15:0] : mask_reg;
  wire logic        gie_next     = global_irq_disable_instr ? 1'b0 :
                                   (global_irq_enable_instr ? 1'b1 : gie_reg);
  // Events 0 to 6 are never gated, so only the general-purpose inputs follow the global enable.
  wire logic [15:0] gp_gate_w    = {{tlec_pkg::NUM_GP{gie_next}}, 7'h7F};
  wire logic [15:0] svc_w        = latch_next & mask_next & gp_gate_w;
  wire logic [4:0]  svc_top_w    = first_set(svc_w);
  wire logic [4:0]  act_top_w    = first_set(pending_next);
  // Only an event of higher priority than every active one may nest.
  wire logic        req_next     = (svc_top_w < act_top_w);

  // The previous level resets low, the idle level of every input, so leaving reset makes no false edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      edge_prev_reg <= 16'h0000;
      rise_reg      <= 16'h0000;
    end
    else
    begin
      edge_prev_reg <= evt_in_w;
      rise_reg      <= evt_in_w & ~edge_prev_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_reg   <= 16'h0000;
      pending_reg <= 16'h0000;
      mask_reg    <= tlec_pkg::RST_CORE_MASK;
      gie_reg     <= tlec_pkg::RST_GIE;
      evt_req     <= 1'b0;
      evt_req_id  <= 4'h0;
    end
    else
    begin
      latch_reg   <= latch_next;
      pending_reg <= pending_next;
      mask_reg    <= mask_next;
      gie_reg     <= gie_next;
      // The offer is registered so the pipeline sees a steady id for a whole cycle.
      evt_req     <= req_next;
      evt_req_id  <= svc_top_w[3:0];
    end
  end

  // ========================================================================
  // System stage registers.
  // ========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smask_reg <= tlec_pkg::RST_SYS_MASK;
      wake_reg  <= tlec_pkg::RST_WAKE;
      for (int s = 0; s < tlec_pkg::NUM_SRC; s++)
        asg_reg[s] <= tlec_pkg::RST_ASG_ALL[s*tlec_pkg::ASG_W +: tlec_pkg::ASG_W];
    end
    else if (wr_w)
    begin
      if (sel_smask)
        smask_reg[{hi_w, 5'h00} +: 32] <= pwdata;
      if (sel_wake)
        wake_reg[{hi_w, 5'h00} +: 32] <= pwdata;
      if (sel_asg)
        for (int s = 0; s < 8; s++)
          asg_reg[{paddr[4:2], 3'(s)}] <= pwdata[s*tlec_pkg::ASG_W +: tlec_pkg::ASG_W];
    end
  end

  // ========================================================================
  // Wakeup and block interrupt.
  // ========================================================================
  wire logic                     wake_now_w = core_idle & wake_src_w;
  // An edge that meets a still-latched bit merges into it and is reported as an overrun.
  wire logic                     ovr_w      = |(rise_reg & latch_reg & ~pend_set_w);
  wire logic [tlec_pkg::EV_W-1:0] ev_set_w  = {ovr_w, acc_w & err_w, wake_now_w & ~core_wakeup};
  wire logic [tlec_pkg::EV_W-1:0] ev_clr_w  = (wr_w & sel_evclr) ? pwdata[tlec_pkg::EV_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_wakeup <= 1'b0;
      evstat_reg  <= '0;
      even_reg    <= tlec_pkg::RST_EVEN;
    end
    else
    begin
      // The wake level follows the wakeup-enabled sources only while the idle input is high; a busy core never sees it.
      core_wakeup <= wake_now_w;
      // A new event in the clearing cycle survives the clear.
      evstat_reg  <= (evstat_reg & ~ev_clr_w) | ev_set_w;
      if (wr_w && sel_even)
        even_reg <= pwdata[tlec_pkg::EV_W-1:0];
    end
  end

  assign irq = |(evstat_reg & even_reg);

  // ========================================================================
  // Read data, captured in the setup cycle and held through the access.
  // ========================================================================
  logic [31:0] rdata_w;
  // Capturing at setup keeps the read data steady through the access, at the cost of one cycle of age.

  always_comb
  begin
    rdata_w = 32'h0000_0000;
    if (sel_latch)
      rdata_w = {16'h0000, latch_reg};
    else if (sel_mask)
      rdata_w = {16'h0000, mask_reg};
    else if (sel_pend)
      rdata_w = {16'h0000, pending_reg};
    else if (sel_gie)
      rdata_w = {31'h0000_0000, gie_reg};
    else if (sel_smask)
      rdata_w = smask_reg[{hi_w, 5'h00} +: 32];
    else if (sel_sstat)
      rdata_w = periph_irq[{hi_w, 5'h00} +: 32];
    else if (sel_wake)
      rdata_w = wake_reg[{hi_w, 5'h00} +: 32];
    else if (sel_evst)
      rdata_w = {29'h0000_0000, evstat_reg};
    else if (sel_even)
      rdata_w = {29'h0000_0000, even_reg};
    else if (sel_asg)
      for (int s = 0; s < 8; s++)
        rdata_w[s*tlec_pkg::ASG_W +: tlec_pkg::ASG_W] = asg_reg[{paddr[4:2], 3'(s)}];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_w)
      prdata <= (err_w | pwrite) ? 32'h0000_0000 : rdata_w;
  end

  // ========================================================================
  // Checks.
  // ========================================================================
  AST_EDGE_TWO: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(evt_in_w[7]) |-> ##2 latch_reg[7])
    else $error("Input edge did not set the latch two cycles later.");

  AST_LATCH_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (take_w && ((rise_reg & pend_set_w) == 16'h0000)) |=> ((latch_reg & $past(pend_set_w)) == 16'h0000))
    else $error("Latch bit not cleared when its pending bit was set.");

  AST_PEND_SET: assert property (@(posedge pclk) disable iff (!presetn)
    take_w |=> pending_reg[$past(pipe_accept_id)])
    else $error("Accepted event is not marked pending.");

  AST_PEND_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pending_reg[7]) |-> ($past(latch_reg[7]) && $past(edge_prev_reg[7], 2)))
    else $error("Pending set without a latched edge at least three cycles back.");

  AST_MASK_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    evt_req |-> (mask_reg[evt_req_id] && latch_reg[evt_req_id]))
    else $error("Request offered for a masked or unlatched event.");

  AST_GLOBAL: assert property (@(posedge pclk) disable iff (!presetn)
    (evt_req && (evt_req_id >= 4'(tlec_pkg::GP_BASE))) |-> gie_reg)
    else $error("General-purpose event offered while globally disabled.");

  AST_SUPV: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_w && !pprot[0] && (sel_mask || sel_pend)) |-> (pslverr ##1 $stable(mask_reg)))
    else $error("Unprivileged core mask or pending access was not refused.");

  AST_PEND_RO: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_w && pwrite && sel_pend && !pipe_accept && !pipe_return) |=> $stable(pending_reg))
    else $error("Software write changed the pending register.");

  AST_SYS_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    ((periph_irq & smask_reg) == 64'h0) |-> (gp_vec == 9'h000))
    else $error("Masked sources reached a core input.");

  AST_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_w && !pwrite && sel_sstat && !hi_w) |=> (prdata == $past(periph_irq[31:0])))
    else $error("Status read does not reflect the live source levels.");

  AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (core_idle && wake_src_w) |=> core_wakeup)
    else $error("Wakeup-enabled source did not wake the idle core.");

  AST_WAKE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !core_idle |=> !core_wakeup)
    else $error("Wakeup raised while the core was not idle.");

  AST_LATCH_WR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_w && sel_latch) |=> (((latch_reg ^ $past(latch_reg)) & $past(mask_reg & ~rise_reg & ~pend_set_w)) == 16'h0000))
    else $error("Software write changed a latch bit whose mask bit is set.");

  AST_PEND_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!take_w && !pipe_return) |=> $stable(pending_reg))
    else $error("Pending changed without an acceptance or a return.");

  AST_LATCH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (latch_reg[13] && !take_w && !(wr_w && sel_latch)) |=> latch_reg[13])
    else $error("Latch bit dropped before its event entered the pipeline.");

  AST_GIE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    global_irq_disable_instr |=> !gie_reg)
    else $error("Global disable did not take effect.");

  AST_NEST: assert property (@(posedge pclk) disable iff (!presetn)
    evt_req |-> ((pending_reg << (4'hF - evt_req_id)) == 16'h0000))
    else $error("Offered event does not outrank every active event.");

  // Source 42 stands for every route; each source uses the same generated logic.
  AST_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
    (periph_irq[42] && smask_reg[42] && (asg_reg[42] < 4'(tlec_pkg::NUM_GP))) |-> gp_vec[asg_reg[42]])
    else $error("Unmasked source did not reach its assigned input.");

endmodule

`default_nettype wire

// ===== tb/tlec_pipe_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Pipeline stand-in: takes offered events after a delay,
// nests them on a small stack and retires the newest later.
// ==========================================================
module tlec_pipe_model
(
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Offer from the controller, and the acceptance delay.
  input  wire logic       evt_req,
  input  wire logic [3:0] evt_req_id,
  input  wire logic [3:0] accept_delay,
  // Acceptance and retirement.
  output var  logic       pipe_accept,
  output var  logic [3:0] pipe_accept_id,
  output var  logic       pipe_return,
  output var  logic [3:0] pipe_return_id
);
  localparam int HOLD = 24;
  logic [3:0] stack [4];
  logic [2:0] sp;
  logic [3:0] wait_cnt;
  logic [7:0] hold_cnt;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pipe_accept    <= 1'b0;
      pipe_return    <= 1'b0;
      pipe_accept_id <= 4'h0;
      pipe_return_id <= 4'h0;
      sp             <= 3'h0;
      wait_cnt       <= 4'h0;
      hold_cnt       <= 8'h00;
    end
    else
    begin
      // Idle id lines toggle so a stale id is never mistaken for a live one.
      pipe_accept    <= 1'b0;
      pipe_return    <= 1'b0;
      pipe_accept_id <= ~pipe_accept_id;
      pipe_return_id <= ~pipe_return_id;
      if (evt_req && !pipe_accept && wait_cnt >= accept_delay && sp < 3'h4)
      begin
        pipe_accept    <= 1'b1;
        pipe_accept_id <= evt_req_id;
        stack[sp[1:0]] <= evt_req_id;
        sp             <= sp + 3'h1;
        hold_cnt       <= 8'(HOLD);
        wait_cnt       <= 4'h0;
      end
      else if (evt_req && !pipe_accept)
        wait_cnt <= wait_cnt + 4'h1;
      else if (sp != 3'h0 && hold_cnt == 8'h00)
      begin
        pipe_return    <= 1'b1;
        pipe_return_id <= stack[2'(sp - 3'h1)];
        sp             <= sp - 3'h1;
        hold_cnt       <= 8'(HOLD);
      end
      else if (sp != 3'h0)
        hold_cnt <= hold_cnt - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {logic rd; logic [31:0] d; logic err;} tlec_exp_t;
  localparam logic [2:0]  SU  = 3'h1;
  localparam logic [2:0]  US  = 3'h0;
  localparam logic [63:0] B42 = 64'h0000_0400_0000_0000;
  localparam logic [63:0] B43 = 64'h0000_0800_0000_0000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  pprot;
  logic [63:0] periph_irq, rnd;
  logic        gie_on, gie_off, core_idle, core_wakeup, evt_req, evt_prev;
  logic        pipe_accept, pipe_return;
  logic [3:0]  evt_req_id, pipe_accept_id, pipe_return_id, acc_dly;
  int          err_count, cmp_count, lat;
  tlec_exp_t   e;
  tlec_exp_t   exp_q[$];
  logic [3:0]  ev_q[$];

  tlec_top u_tlec_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata,
    .pready, .pslverr, .periph_irq, .core_fixed_evt(7'h00), .global_irq_enable_instr(gie_on),
    .global_irq_disable_instr(gie_off), .core_idle, .pipe_accept, .pipe_accept_id, .pipe_return,
    .pipe_return_id, .evt_req, .evt_req_id, .core_wakeup, .irq);
  tlec_pipe_model u_tlec_pipe_model (.pclk, .presetn, .evt_req, .evt_req_id, .accept_delay(acc_dly),
    .pipe_accept, .pipe_accept_id, .pipe_return, .pipe_return_id);

  always #5 pclk = ~pclk;

  // ==========================================================
  // Reporting.
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 100)
    begin
      err_count++;
      $display("ERROR %0t: wait ran out", $time);
      close_out();
    end
  endtask

  // ==========================================================
  // Drivers. Every change follows a rising edge.
  // ==========================================================
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p,
                     input logic [31:0] ed, input logic ee);
    int n;
    exp_q.push_back('{!w, ed, ee});
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pprot   <= p;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    hang(n);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [2:0] p, input logic [31:0] ed, input logic ee);
    apb(1'b0, a, 32'h0, p, ed, ee);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p, input logic ee);
    apb(1'b1, a, d, p, 32'h0, ee);
  endtask

  task automatic src(input logic [63:0] v);
    @(posedge pclk);
    periph_irq <= v;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_on(input logic ret, output int n);
    n = 0;
    while ((ret ? pipe_return : evt_req) !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    hang(n);
  endtask

  // ==========================================================
  // Watcher: takes the oldest note whenever a result shows.
  // ==========================================================
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e.rd)
        check(prdata, e.d);
      check({31'h0, pslverr}, {31'h0, e.err});
    end
    evt_prev <= evt_req;
    if (evt_req === 1'b1 && evt_prev !== 1'b1)
    begin
      if (ev_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check({28'h0, evt_req_id}, {28'h0, ev_q.pop_front()});
    end
  end

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, gie_on, gie_off, core_idle} = 8'h00;
    {paddr, pwdata, pprot, periph_irq, acc_dly} = '0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(32'h5EF5FBC6));
    idle(8);
    presetn <= 1'b1;
    rd(tlec_pkg::OFF_MASK, SU, 32'h0, 1'b0);
    rd(tlec_pkg::OFF_PEND, SU, 32'h0, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      rd(8'(tlec_pkg::OFF_SMASK + 4 * i), US, 32'h0, 1'b0);
      rd(8'(tlec_pkg::OFF_WAKE + 4 * i), US, 32'h0, 1'b0);
    end
    for (int i = 0; i < 8; i++)
      rd(8'(tlec_pkg::OFF_ASG + 4 * i), US, tlec_pkg::RST_ASG_ALL[32 * i +: 32], 1'b0);
    // Refused accesses, then the block interrupt masked, raised and cleared.
    rd(tlec_pkg::OFF_MASK, US, 32'h0, 1'b1);
    rd(tlec_pkg::OFF_PEND, US, 32'h0, 1'b1);
    wr(tlec_pkg::OFF_PEND, 32'hFFFF, SU, 1'b1);
    rd(8'hFC, SU, 32'h0, 1'b1);
    rd(tlec_pkg::OFF_EVSTAT, US, 32'h2, 1'b0);
    check({31'h0, irq}, 32'h0);
    wr(tlec_pkg::OFF_EVEN, 32'h2, US, 1'b0);
    #1 check({31'h0, irq}, 32'h1);
    wr(tlec_pkg::OFF_EVCLR, 32'h2, US, 1'b0);
    #1 check({31'h0, irq}, 32'h0);
    // Live status with every source masked: nothing may reach the core.
    rnd = {$urandom, $urandom};
    src(rnd);
    rd(tlec_pkg::OFF_SSTAT, US, rnd[31:0], 1'b0);
    rd(8'(tlec_pkg::OFF_SSTAT + 4), US, rnd[63:32], 1'b0);
    src(64'h0);
    // Latched while globally disabled, offered once enabled.
    acc_dly <= 4'($urandom % 4);
    wr(tlec_pkg::OFF_MASK, 32'h2000, SU, 1'b0);
    wr(8'(tlec_pkg::OFF_SMASK + 4), 32'h400, US, 1'b0);
    src(B42);
    idle(3);
    rd(tlec_pkg::OFF_LATCH, US, 32'h2000, 1'b0);
    ev_q.push_back(4'hD);
    gie_on <= 1'b1;
    @(posedge pclk) gie_on <= 1'b0;
    wait_on(1'b0, lat);
    idle(6);
    rd(tlec_pkg::OFF_PEND, SU, 32'h2000, 1'b0);
    rd(tlec_pkg::OFF_LATCH, US, 32'h0, 1'b0);
    wait_on(1'b1, lat);
    src(64'h0);
    // Two-cycle detection, merged sources, and an edge queued while pending.
    wr(8'(tlec_pkg::OFF_SMASK + 4), 32'hC00, US, 1'b0);
    ev_q.push_back(4'hD);
    src(B42);
    wait_on(1'b0, lat);
    check(lat, 32'h2);
    idle(6);
    src(B42 | B43);
    src(B43);
    src(64'h0);
    src(B43);
    ev_q.push_back(4'hD);
    wait_on(1'b1, lat);
    wait_on(1'b0, lat);
    @(posedge pclk);
    wait_on(1'b1, lat);
    src(64'h0);
    // Core mask clear keeps the latch and allows software to clear it.
    wr(tlec_pkg::OFF_MASK, 32'h0, SU, 1'b0);
    src(B42);
    idle(3);
    rd(tlec_pkg::OFF_LATCH, US, 32'h2000, 1'b0);
    wr(tlec_pkg::OFF_LATCH, 32'h0, US, 1'b0);
    rd(tlec_pkg::OFF_LATCH, US, 32'h0, 1'b0);
    wr(tlec_pkg::OFF_MASK, 32'h2000, SU, 1'b0);
    wr(tlec_pkg::OFF_LATCH, 32'h2000, US, 1'b0);
    rd(tlec_pkg::OFF_LATCH, US, 32'h0, 1'b0);
    src(64'h0);
    // Rerouted source with wakeup enabled while the core idles.
    wr(8'(tlec_pkg::OFF_ASG + 20), 32'h06666055, US, 1'b0);
    wr(tlec_pkg::OFF_MASK, 32'h2080, SU, 1'b0);
    wr(8'(tlec_pkg::OFF_WAKE + 4), 32'h400, US, 1'b0);
    core_idle <= 1'b1;
    ev_q.push_back(4'h7);
    src(B42);
    @(posedge pclk) #1 check({31'h0, core_wakeup}, 32'h1);
    wait_on(1'b0, lat);
    rd(tlec_pkg::OFF_EVSTAT, US, 32'h1, 1'b0);
    wait_on(1'b1, lat);
    src(64'h0);
    @(posedge pclk) #1 check({31'h0, core_wakeup}, 32'h0);
    // Globally disabled: latched but held back until enabled again.
    @(posedge pclk) gie_off <= 1'b1;
    @(posedge pclk) gie_off <= 1'b0;
    rd(tlec_pkg::OFF_GIE, US, 32'h0, 1'b0);
    src(B42);
    idle(3);
    rd(tlec_pkg::OFF_LATCH, US, 32'h0080, 1'b0);
    ev_q.push_back(4'h7);
    gie_on <= 1'b1;
    @(posedge pclk) gie_on <= 1'b0;
    wait_on(1'b0, lat);
    wait_on(1'b1, lat);
    src(64'h0);
    idle(4);
    check(ev_q.size(), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
